/* File: core/reset_seq_pkg.sv */
// Purpose: Shared constants and types for the reset source sequencer.
// Assumes: 100 MHz core clock; register access over AHB-Lite, word aligned.
// Notes: Long start-up times are top-level parameters so benches can shorten them.
package reset_seq_pkg;

  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register byte offsets.
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;

  // Cause register field positions; bits 7 to 5 are unused.
  localparam int unsigned BIT_SUPPLY = 0;
  localparam int unsigned BIT_PIN = 1;
  localparam int unsigned BIT_BROWNOUT = 2;
  localparam int unsigned BIT_WATCHDOG = 3;
  localparam int unsigned BIT_TESTPORT = 4;
  localparam logic [7:0] CAUSE_MASK = 8'h1f;
  localparam logic [7:0] CAUSE_RESET = 8'h00;

  // Control register fields.
  localparam int unsigned BIT_CMP_BG = 0;
  localparam int unsigned BIT_CONV_EN = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h0;

  // Brown-out level setting codes.
  localparam logic [2:0] BOD_LEVEL_OFF = 3'h7;
  localparam logic [2:0] BOD_LEVEL_MAX = 3'h3;

  // Least brown-out duration in ns and its cycle count, rounded up.
  localparam int unsigned BROWNOUT_MIN_NS = 2000;
  localparam int unsigned BROWNOUT_MIN_CYC =
    (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Shortest start-up delay, and extra cycles added for a crystal source.
  localparam int unsigned STARTUP_SHORT_CYC = 6;
  localparam int unsigned CRYSTAL_EXTRA_CYC = 16;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN = 3'b100
  } seqState_t;

  // Reset sources as seen on the clock domain.
  typedef struct packed {
    logic testPort;
    logic watchdog;
    logic brownout;
    logic pin;
    logic supply;
  } resetSources_t;

endpackage : reset_seq_pkg

/* File: core/reset_source_sequencer.sv */
// Purpose: Merges reset sources into one internal reset, stretches it, logs cause.
// Assumes: Watchdog pulse is on core_clk; supply, pin, brown-out and test port are not.
// Notes: Register file is a zero-wait AHB-Lite slave that always answers OKAY.
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps

module reset_source_sequencer #(
  parameter int unsigned CNT_W = 24,
  parameter int unsigned STARTUP_MID_US = 4100,
  parameter int unsigned STARTUP_LONG_US = 65000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic supplyLow,
  input wire logic pinReset_n,
  input wire logic brownoutLow,
  input wire logic [2:0] brownoutLevelSetting,
  input wire logic watchdogResetPulse,
  input wire logic testPortReset,
  input wire logic [1:0] startupTimeFuses,
  input wire logic [3:0] clockSelectFuses,
  output logic internalReset,
  output logic portReset,
  output logic bandgapEnable,
  output logic [1:0] brownoutTriggerLevel
);

  // Start-up periods in cycles, derived from their times.
  localparam int unsigned MID_CYC = STARTUP_MID_US * 1000 / reset_seq_pkg::CLK_PERIOD_NS;
  localparam int unsigned LONG_CYC = STARTUP_LONG_US * 1000 / reset_seq_pkg::CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  // Picks the start-up delay from the fuses; a crystal source gets extra cycles.
  function automatic logic [CNT_W-1:0] startupCycles(input logic [1:0] startup_time_fuses,
                                                     input logic [3:0] clock_select_fuses);
    logic [CNT_W-1:0] base;
    base = CNT_W'(reset_seq_pkg::STARTUP_SHORT_CYC);
    if (startup_time_fuses[1]) begin
      base = CNT_W'(LONG_CYC);
    end else if (startup_time_fuses[0]) begin
      base = CNT_W'(MID_CYC);
    end
    if (clock_select_fuses[3]) begin
      base = base + CNT_W'(reset_seq_pkg::CRYSTAL_EXTRA_CYC);
    end
    return base;
  endfunction : startupCycles

  // Raw asynchronous sources, active high: test port, brown-out, pin, supply.
  logic [3:0] rawSrc;
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic [3:0] syncC_q;
  logic [3:0] stable_q;
  logic bodEnabled;
  logic [15:0] bodCnt_q;
  logic bodQual_q;
  reset_seq_pkg::resetSources_t src;
  logic anySource;
  reset_seq_pkg::seqState_t state_q;
  logic [CNT_W-1:0] delayCnt_q;
  logic [7:0] cause_q;
  logic [1:0] control_q;
  logic bandgap_q;
  logic [1:0] level_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdata_q;
  logic addrPhase;
  logic causeWrite;
  logic controlWrite;

  assign rawSrc = {testPortReset, brownoutLow, ~pinReset_n, supplyLow};

  // Three-stage synchroniser; a level is taken once stages two and three agree.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 4'h0;
      syncB_q <= 4'h0;
      syncC_q <= 4'h0;
      stable_q <= 4'h0;
    end else begin
      syncA_q <= rawSrc;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      stable_q <= (syncB_q & syncC_q) | (stable_q & (syncB_q | syncC_q));
    end
  end

  // Reserved and all-ones codes leave the monitor off.
  assign bodEnabled = (brownoutLevelSetting <= reset_seq_pkg::BOD_LEVEL_MAX);

  // A dip must last the least duration before it counts as a brown-out.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bodCnt_q <= 16'h0000;
      bodQual_q <= 1'b0;
    end else if (!(stable_q[2] && bodEnabled)) begin
      bodCnt_q <= 16'h0000;
      bodQual_q <= 1'b0;
    end else if (bodCnt_q < 16'(reset_seq_pkg::BROWNOUT_MIN_CYC)) begin
      bodCnt_q <= bodCnt_q + 16'h0001;
    end else begin
      bodQual_q <= 1'b1;
    end
  end

  // Watchdog arrives as a single-cycle pulse; the test port and the rest are synchronised.
  assign src.supply = stable_q[0];
  assign src.pin = stable_q[1];
  assign src.brownout = bodQual_q;
  assign src.watchdog = watchdogResetPulse;
  assign src.testPort = stable_q[3];
  assign anySource = |src;

  // Hold while any source is active, then stretch by the start-up delay.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= reset_seq_pkg::ST_HOLD;
      delayCnt_q <= '0;
    end else if (anySource) begin
      state_q <= reset_seq_pkg::ST_HOLD;
      delayCnt_q <= '0;
    end else begin
      unique case (state_q)
        reset_seq_pkg::ST_HOLD: begin
          // First quiet cycle: for the watchdog this is its falling edge.
          state_q <= reset_seq_pkg::ST_STRETCH;
          delayCnt_q <= startupCycles(startupTimeFuses, clockSelectFuses);
        end
        reset_seq_pkg::ST_STRETCH: begin
          if (delayCnt_q <= ONE) begin
            state_q <= reset_seq_pkg::ST_RUN;
            delayCnt_q <= '0;
          end else begin
            delayCnt_q <= delayCnt_q - ONE;
          end
        end
        reset_seq_pkg::ST_RUN: begin
          delayCnt_q <= '0;
        end
        default: begin
          state_q <= reset_seq_pkg::ST_HOLD;
          delayCnt_q <= '0;
        end
      endcase
    end
  end

  // Raw supply and pin feed the reset directly so no clock is needed to assert it.
  // The watchdog pulse itself is exactly one cycle wide.
  assign portReset = supplyLow | ~pinReset_n | testPortReset | bodQual_q
                     | watchdogResetPulse;
  assign internalReset = portReset | (state_q != reset_seq_pkg::ST_RUN);

  // AHB-Lite address phase; the slave never inserts wait states.
  assign addrPhase = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign causeWrite = wrPend_q & (wrAddr_q == reset_seq_pkg::OFS_CAUSE);
  assign controlWrite = wrPend_q & (wrAddr_q == reset_seq_pkg::OFS_CONTROL);

  // Captures a write address for the data phase and latches read data early.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      wrAddr_q <= haddr[7:0];
      rdata_q <= 32'h0000_0000;
      if (addrPhase && !hwrite && haddr[31:8] == 24'h00_0000) begin
        unique case (haddr[7:0])
          reset_seq_pkg::OFS_CAUSE: rdata_q <= {24'h00_0000, cause_q};
          reset_seq_pkg::OFS_CONTROL: rdata_q <= {30'h0000_0000, control_q};
          reset_seq_pkg::OFS_STATE: rdata_q <= {19'h0_0000, delayActiveBits()};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Live state word: level, enables, sequencer state and active sources.
  // Thirteen bits: level 2, enable 1, bandgap 1, state 3, sources 5, reset 1.
  function automatic logic [12:0] delayActiveBits();
    return {level_q, bodEnabled, bandgap_q, state_q, src, internalReset};
  endfunction : delayActiveBits

  // Cause flags: a zero written clears, a source setting in the same cycle wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= reset_seq_pkg::CAUSE_RESET;
    end else begin
      logic [7:0] keep;
      keep = causeWrite ? (cause_q & hwdata[7:0]) : cause_q;
      if (src.supply) begin
        keep = 8'h00;
        keep[reset_seq_pkg::BIT_SUPPLY] = 1'b1;
      end else begin
        keep[reset_seq_pkg::BIT_PIN] = keep[reset_seq_pkg::BIT_PIN] | src.pin;
        keep[reset_seq_pkg::BIT_BROWNOUT] =
          keep[reset_seq_pkg::BIT_BROWNOUT] | src.brownout;
        keep[reset_seq_pkg::BIT_WATCHDOG] =
          keep[reset_seq_pkg::BIT_WATCHDOG] | src.watchdog;
        keep[reset_seq_pkg::BIT_TESTPORT] =
          keep[reset_seq_pkg::BIT_TESTPORT] | src.testPort;
      end
      cause_q <= keep & reset_seq_pkg::CAUSE_MASK;
    end
  end

  // Control register holds the comparator bandgap select and converter enable.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= reset_seq_pkg::CONTROL_RESET;
    end else if (controlWrite) begin
      control_q <= hwdata[1:0];
    end
  end

  // Reference and trigger level are registered to keep the outputs glitch free.
  // Software must still allow the reference to settle after turning it on.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_q <= 1'b0;
      level_q <= 2'h0;
    end else begin
      bandgap_q <= bodEnabled | control_q[reset_seq_pkg::BIT_CMP_BG]
                   | control_q[reset_seq_pkg::BIT_CONV_EN];
      level_q <= bodEnabled ? (2'h3 - brownoutLevelSetting[1:0]) : 2'h0;
    end
  end

  assign bandgapEnable = bandgap_q;
  assign brownoutTriggerLevel = level_q;

endmodule : reset_source_sequencer

/* File: tb/reset_source_sequencer_chk.sv */
// Purpose: Port checks for the reset sequencer.
// Assumes: Fuses set for the six-cycle start-up until the last bench test lengthens it.
// Notes: Brown-out bounds leave room for input syncing.
`timescale 1ns/1ps
module reset_source_sequencer_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supplyLow,
  input wire logic pinReset_n,
  input wire logic brownoutLow,
  input wire logic [2:0] brownoutLevelSetting,
  input wire logic watchdogResetPulse,
  input wire logic testPortReset,
  input wire logic internalReset,
  input wire logic portReset,
  input wire logic bandgapEnable,
  input wire logic [1:0] brownoutTriggerLevel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] run_q;
  logic quiet;
  logic bodOn;
  // The filter check needs every source but the brown-out idle.
  assign quiet = !supplyLow && pinReset_n && !testPortReset && !watchdogResetPulse;
  assign bodOn = !brownoutLevelSetting[2];
  // Length of the present brown-out report, held at its top so it cannot wrap.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) run_q <= 8'h00;
    else if (!brownoutLow) run_q <= 8'h00;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;
  end
  supply_hold_a: assert property (supplyLow |-> internalReset && portReset)
    else $error("supply low without reset");
  supply_stretch_a: assert property ($fell(supplyLow) |-> internalReset[*5])
    else $error("supply release cut short");
  pin_hold_a: assert property (!pinReset_n |-> internalReset && portReset)
    else $error("pin low without reset");
  pin_stretch_a: assert property ($rose(pinReset_n) |-> internalReset[*5])
    else $error("pin release cut short");
  wdog_stretch_a: assert property (watchdogResetPulse |-> internalReset[*6])
    else $error("watchdog reset cut short");
  test_hold_a: assert property (testPortReset |-> internalReset)
    else $error("test port without reset");
  bod_fire_a: assert property (run_q == 8'd215 && bodOn |-> internalReset)
    else $error("brown-out not taken");
  bod_quiet_a: assert property (quiet && brownoutLow && (run_q < 8'd150 || !bodOn)
    && !$past(internalReset) |-> !internalReset) else $error("brown-out not filtered");
  level_code_a: assert property (bodOn |=>
    brownoutTriggerLevel == 2'h3 - $past(brownoutLevelSetting[1:0])) else $error("bad level");
  bandgap_on_a: assert property (bodOn |=> bandgapEnable)
    else $error("bandgap off with brown-out on");
  // Main scenarios reached.
  cover property (watchdogResetPulse);
  cover property (run_q == 8'd215 && bodOn);
  cover property ($fell(internalReset));
endmodule : reset_source_sequencer_chk

/* File: tb/reset_source_model.sv */
// Purpose: Reset sources around the sequencer.
// Assumes: Levels change just after rising edges.
// Notes: Supply starts low so the first run is a power-on.
`timescale 1ns/1ps
module reset_source_model (
  input wire logic core_clk,
  output logic supplyLow,
  output logic pinReset_n,
  output logic brownoutLow,
  output logic watchdogResetPulse,
  output logic testPortReset
);
  // Power-up state: supply below its level, all else idle.
  initial begin
    supplyLow = 1'b1;
    pinReset_n = 1'b1;
    brownoutLow = 1'b0;
    watchdogResetPulse = 1'b0;
    testPortReset = 1'b0;
  end
  // Raise source k for n cycles; the watchdog only ever pulses for one.
  task automatic drive(input int k, input int n);
    @(posedge core_clk);
    case (k)
      0: supplyLow <= 1'b1;
      1: pinReset_n <= 1'b0;
      2: brownoutLow <= 1'b1;
      3: watchdogResetPulse <= 1'b1;
      default: testPortReset <= 1'b1;
    endcase
    repeat (k == 3 ? 1 : n) @(posedge core_clk);
    supplyLow <= 1'b0;
    pinReset_n <= 1'b1;
    brownoutLow <= 1'b0;
    watchdogResetPulse <= 1'b0;
    testPortReset <= 1'b0;
  endtask : drive
endmodule : reset_source_model

/* File: tb/reset_source_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the reset source sequencer.
// Assumes: Fuses set for a six-cycle start-up until the last test lengthens it.
// Notes: Read data is taken at the edge closing the data phase.
`timescale 1ns/1ps
module reset_source_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] brownoutLevelSetting = 3'h7;
  logic [1:0] startupTimeFuses = 2'h0;
  logic [3:0] clockSelectFuses = 4'h0;
  logic hreadyout, hresp, internalReset, portReset, bandgapEnable;
  logic supplyLow, pinReset_n, brownoutLow, watchdogResetPulse, testPortReset;
  logic [31:0] hrdata, rdS, rd;
  logic [1:0] brownoutTriggerLevel;
  int errors = 0;
  int samplesChecked = 0;
  int cycleCount = 0;
  always #5 core_clk = ~core_clk;
  // Capturing by edge keeps the read free of a race with the slave's update.
  always @(posedge core_clk) rdS <= hrdata;
  // The run needs about 1300 cycles; far beyond that it has hung.
  always @(posedge core_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 10000) begin
      errors = errors + 1;
      results();
    end
  end
  reset_source_model reset_source_model_i (.*);
  reset_source_sequencer #(.STARTUP_MID_US(1), .STARTUP_LONG_US(2)) reset_source_sequencer_i (
    .*, .hsel(1'b1), .hready(hreadyout), .hsize(3'h2));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single transfer; both phases wait for ready, however slow.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    #1 rd = rdS;
  endtask : xfer
  // Fire one source, wait for the run state, then read, keep and clear the cause.
  task automatic cause(input int k, input int n, input logic [31:0] exp);
    int c = 0;
    reset_source_model_i.drive(k, n);
    while (internalReset !== 1'b0 && c < 400) begin
      @(posedge core_clk);
      c++;
    end
    chk({31'h0, internalReset}, 32'h0);
    xfer(1'b0, reset_seq_pkg::OFS_CAUSE, 32'h0);
    chk(rd, exp);
    xfer(1'b1, reset_seq_pkg::OFS_CAUSE, 32'hff);
    xfer(1'b0, reset_seq_pkg::OFS_CAUSE, 32'h0);
    chk(rd, exp);
    xfer(1'b1, reset_seq_pkg::OFS_CAUSE, 32'h0);
    xfer(1'b0, reset_seq_pkg::OFS_CAUSE, 32'h0);
    chk(rd, 32'h0);
  endtask : cause
  task automatic results();
    $display("checked %0d, errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Sources one by one, then the brown-out filter, then bandgap and level decode.
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    cause(0, 30, 32'h1);
    cause(1, 20, 32'h2);
    cause(3, 1, 32'h8);
    cause(4, 20, 32'h10);
    reset_source_model_i.drive(1, 20);
    cause(0, 20, 32'h1);
    $display("test sources done");
    @(posedge core_clk) brownoutLevelSetting <= 3'h0;
    cause(2, 300, 32'h4);
    cause(2, 100, 32'h0);
    @(posedge core_clk) brownoutLevelSetting <= 3'h5;
    cause(2, 300, 32'h0);
    $display("test brownout done");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) brownoutLevelSetting <= 3'(i);
      xfer(1'b1, reset_seq_pkg::OFS_CONTROL, 32'h0);
      chk({31'h0, bandgapEnable}, {31'h0, i < 4});
      if (i < 4) chk({30'h0, brownoutTriggerLevel}, 32'(3 - i));
    end
    for (int i = 1; i < 4; i++) begin
      xfer(1'b1, reset_seq_pkg::OFS_CONTROL, 32'(i));
      xfer(1'b0, reset_seq_pkg::OFS_CONTROL, 32'h0);
      chk(rd, 32'(i));
      chk({31'h0, bandgapEnable}, 32'h1);
    end
    xfer(1'b1, reset_seq_pkg::OFS_CONTROL, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, bandgapEnable}, 32'h0);
    $display("test bandgap done");
    // Longer start-up from the fuses must still release and log the watchdog.
    @(posedge core_clk) startupTimeFuses <= 2'h1;
    clockSelectFuses <= 4'h8;
    cause(3, 1, 32'h8);
    $display("test fuses done");
    results();
  end
endmodule : reset_source_sequencer_tb_top
bind reset_source_sequencer reset_source_sequencer_chk reset_source_sequencer_chk_i (.*);
